/* File: hw/ofc_pkg.sv */
// Purpose: shared constants and types of the out-of-band flow-control block
// Assumes: one 40 MHz clock (mclk) acts as the twice-rate tx clock and the rx app clock
// Notes: frame = calendar(16) crc(4) [lanes link crc(4)], msb first, sync on first bit
//
// What this block does
// [RL1] separate transmit and receive halves, used independently
// [RL2] transmitter makes and forwards its own link clock
// [RL3] link clock is exactly half the tx clock
// [RL4] application supplies tx clock at double rate
// [RL5] tx samples calendar and status on tx clock
// [RL6] tx data and sync change with link clock
// [RL7] transmitter has its own asynchronous reset
// [RL8] status enabled: lanes and link status sent
// [RL9] status disabled: only calendar bits sent
// [RL10] one lane status bit per lane, when enabled
// [RL11] single link status bit sent when enabled
// [RL12] sixteen-bit calendar always serialized
// [RL13] everything goes out on one data bit
// [RL14] separate sync bit marks frame start
// [RL15] partner supplies the receive link clock
// [RL16] rx app clock at least twice link clock
// [RL17] recovered values delivered on rx app clock
// [RL18] one-cycle strobe on good status value
// [RL19] one-cycle error on bad status checksum
// [RL20] one-cycle error on bad calendar checksum
// [RL21] receiver has its own asynchronous reset
// [RL22] same frame and checksum on both ends
// [RL23] link inputs synchronised before any strobe
`default_nettype none

package ofc_pkg;
    // ************************************************************
    // register map (byte addresses, low address byte decoded)
    // ************************************************************
    localparam logic [7:0] OFC_CTRL_ADDR = 8'h00;
    localparam logic [7:0] OFC_TXCAL_ADDR = 8'h04;
    localparam logic [7:0] OFC_TXSTAT_ADDR = 8'h08;
    localparam logic [7:0] OFC_RXCAL_ADDR = 8'h0c;
    localparam logic [7:0] OFC_RXSTAT_ADDR = 8'h10;
    localparam logic [7:0] OFC_RXERR_ADDR = 8'h14;
    localparam int OFC_ENA_BIT = 0;
    localparam int OFC_LINK_BIT = 31;
    localparam int OFC_CNT_W = 16;
    localparam logic [31:0] OFC_RESET_WORD = 32'h0;
    localparam logic [1:0] OFC_HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] OFC_HSIZE_WORD = 3'h2;

    // ************************************************************
    // frame layout and checksum
    // ************************************************************
    localparam int OFC_CAL_BITS = 16;
    localparam int OFC_CRC_BITS = 4;
    localparam logic [3:0] OFC_CRC_INIT = 4'hf;
    localparam logic [3:0] OFC_CRC_POLY = 4'h3;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int OFC_MCLK_NS = 25;
    localparam int OFC_FC_DIV = 2;
    localparam int OFC_FC_NS = OFC_MCLK_NS * OFC_FC_DIV;

    typedef struct packed {
        logic clk;
        logic data;
        logic sync;
    } ofc_link_t;

    typedef enum logic [2:0] {
        OFC_RX_HUNT = 3'b001,
        OFC_RX_CAL = 3'b010,
        OFC_RX_STAT = 3'b100
    } ofc_rx_state_t;
endpackage

`default_nettype wire

/* File: hw/ofc_sync.sv */
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are slow next to mclk
// Notes: first stage is read by the second stage only
`default_nettype none

module ofc_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // two stages, frozen with the clock enable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q <= '0;
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule

`default_nettype wire

/* File: hw/ofc_crc4.sv */
// Purpose: four-bit checksum over a word, msb first
// Assumes: purely combinational
// Notes: shared by transmit and receive so both ends agree
`default_nettype none

module ofc_crc4
    import ofc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    input wire logic [WIDTH-1:0] data,
    output logic [3:0] crc
);
    // bit-serial division unrolled by the loop
    always_comb begin
        logic fb;
        fb = 1'b0;
        crc = OFC_CRC_INIT;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            fb = crc[3] ^ data[i];
            crc = {crc[2:0], 1'b0};
            if (fb) begin
                crc = crc ^ OFC_CRC_POLY;
            end
        end
    end
endmodule

`default_nettype wire

/* File: hw/ofc_top.sv */
// Purpose: out-of-band flow-control transmitter and receiver with AHB-Lite registers
// Assumes: mclk is the twice-rate tx clock and the rx app clock; single word transfers
// Notes: tx, rx and bus each have their own asynchronous reset
`default_nettype none

module ofc_top
    import ofc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic txSideAsyncReset_b,
    input wire logic rxSideAsyncReset_b,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output ofc_link_t txLink,
    input wire ofc_link_t rxLinkPin,
    output logic [15:0] calendarOut,
    output logic [LANES-1:0] laneStatusOut,
    output logic linkStatusOut,
    output logic statusUpdate,
    output logic statusError,
    output logic calendarUpdate,
    output logic calendarError
);
    localparam int ST_W = LANES + 1;
    localparam int CAL_W = OFC_CAL_BITS + OFC_CRC_BITS;
    localparam int FRAME_W = CAL_W + ST_W + OFC_CRC_BITS;
    localparam int LEFT_W = $clog2(FRAME_W + 1);

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    logic aWrite_reg;
    logic [7:0] aAddr_reg;
    logic ctrlEna_reg;
    logic [15:0] txCal_reg;
    logic [LANES-1:0] txLane_reg;
    logic txLink_reg;
    logic [OFC_CNT_W-1:0] calErrCnt_reg;
    logic [OFC_CNT_W-1:0] stErrCnt_reg;
    logic [31:0] rdMux;
    logic aPhase;
    logic wrEn;
    logic errClr;

    assign aPhase = hsel && hready && (htrans == OFC_HTRANS_NONSEQ);
    assign wrEn = ce && aWrite_reg;
    assign errClr = wrEn && (aAddr_reg == OFC_RXERR_ADDR);

    // address phase capture
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aWrite_reg <= 1'b0;
            aAddr_reg <= 8'h00;
        end else if (ce && hready) begin
            aWrite_reg <= aPhase && hwrite && (hsize == OFC_HSIZE_WORD);
            aAddr_reg <= haddr[7:0];
        end
    end

    // zero-wait, always okay
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // software registers feeding the transmitter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrlEna_reg <= 1'b0;
            txCal_reg <= 16'h0000;
            txLane_reg <= '0;
            txLink_reg <= 1'b0;
        end else if (wrEn) begin
            case (aAddr_reg)
                OFC_CTRL_ADDR: ctrlEna_reg <= hwdata[OFC_ENA_BIT];
                OFC_TXCAL_ADDR: txCal_reg <= hwdata[15:0];
                OFC_TXSTAT_ADDR: begin
                    txLane_reg <= hwdata[LANES-1:0];
                    txLink_reg <= hwdata[OFC_LINK_BIT];
                end
                default: ;
            endcase
        end
    end

    // read decode, unmapped reads zero
    always_comb begin
        rdMux = OFC_RESET_WORD;
        case (haddr[7:0])
            OFC_CTRL_ADDR: rdMux[OFC_ENA_BIT] = ctrlEna_reg;
            OFC_TXCAL_ADDR: rdMux[15:0] = txCal_reg;
            OFC_TXSTAT_ADDR: begin
                rdMux[LANES-1:0] = txLane_reg;
                rdMux[OFC_LINK_BIT] = txLink_reg;
            end
            OFC_RXCAL_ADDR: rdMux[15:0] = calendarOut;
            OFC_RXSTAT_ADDR: begin
                rdMux[LANES-1:0] = laneStatusOut;
                rdMux[OFC_LINK_BIT] = linkStatusOut;
            end
            OFC_RXERR_ADDR: rdMux = {stErrCnt_reg, calErrCnt_reg};
            default: rdMux = OFC_RESET_WORD;
        endcase
    end

    // read data launched into the data phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata <= OFC_RESET_WORD;
        end else if (ce && aPhase && !hwrite) begin
            hrdata <= rdMux;
        end
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    logic [FRAME_W-1:0] txSh_reg;
    logic [LEFT_W-1:0] txLeft_reg;
    logic txEnaLat_reg;
    logic [3:0] txCalCrc;
    logic [3:0] txStCrc;
    logic fcFall;
    logic txLoad;

    ofc_crc4 #(.WIDTH(OFC_CAL_BITS)) uTxCalCrc (
        .data(txCal_reg),
        .crc(txCalCrc)
    );
    ofc_crc4 #(.WIDTH(ST_W)) uTxStCrc (
        .data({txLane_reg, txLink_reg}),
        .crc(txStCrc)
    );

    assign fcFall = ce && txLink.clk;
    assign txLoad = fcFall && (txLeft_reg == '0);

    // link clock toggles every tx clock; new bit on each falling link clock
    always_ff @(posedge mclk or negedge txSideAsyncReset_b) begin
        if (!txSideAsyncReset_b) begin // RL7 RL1
            txLink.clk <= 1'b0;
            txSh_reg <= '0;
            txLeft_reg <= '0;
            txEnaLat_reg <= 1'b0;
            txLink.data <= 1'b0;
            txLink.sync <= 1'b0;
        end else if (ce) begin
            txLink.clk <= ~txLink.clk; // RL2 RL3
            if (txLoad) begin
                // inputs sampled here, in the tx clock domain
                txSh_reg <= {txCal_reg[14:0], txCalCrc, txLane_reg, txLink_reg,
                    txStCrc, 1'b0}; // RL5 RL12
                txEnaLat_reg <= ctrlEna_reg;
                txLink.data <= txCal_reg[15]; // RL13 RL6
                txLink.sync <= 1'b1; // RL14
                if (ctrlEna_reg) begin
                    txLeft_reg <= LEFT_W'(FRAME_W - 1); // RL8 RL10 RL11
                end else begin
                    txLeft_reg <= LEFT_W'(CAL_W - 1); // RL9
                end
            end else if (fcFall) begin
                txSh_reg <= {txSh_reg[FRAME_W-2:0], 1'b0};
                txLink.data <= txSh_reg[FRAME_W-1]; // RL6 RL13
                txLink.sync <= 1'b0;
                txLeft_reg <= txLeft_reg - 1'b1;
            end
        end
    end

    // ************************************************************
    // receiver
    // ************************************************************
    ofc_link_t rxSync;
    ofc_rx_state_t rxState_reg;
    logic rxClkPrev_reg;
    logic [LEFT_W-1:0] rxIdx_reg;
    logic [15:0] calSh_reg;
    logic [ST_W-1:0] stSh_reg;
    logic [3:0] chk_reg;
    logic [3:0] rxCalCrc;
    logic [3:0] rxStCrc;
    logic rxRise;
    logic calDone;
    logic stDone;
    logic calGood;
    logic stGood;

    // pins cross into mclk before anything looks at them
    ofc_sync #(.WIDTH(3)) uRxSync ( // RL23
        .mclk(mclk),
        .rst_b(rxSideAsyncReset_b),
        .ce(ce),
        .d(rxLinkPin),
        .q(rxSync)
    );
    ofc_crc4 #(.WIDTH(OFC_CAL_BITS)) uRxCalCrc (
        .data(calSh_reg),
        .crc(rxCalCrc)
    );
    ofc_crc4 #(.WIDTH(ST_W)) uRxStCrc (
        .data(stSh_reg),
        .crc(rxStCrc)
    );

    assign rxRise = ce && rxSync.clk && !rxClkPrev_reg;
    assign calDone = rxRise && !rxSync.sync && (rxState_reg == OFC_RX_CAL)
        && (rxIdx_reg == LEFT_W'(CAL_W - 1));
    assign stDone = rxRise && !rxSync.sync && (rxState_reg == OFC_RX_STAT)
        && (rxIdx_reg == LEFT_W'(FRAME_W - 1));
    assign calGood = ({chk_reg[2:0], rxSync.data} == rxCalCrc); // RL22
    assign stGood = ({chk_reg[2:0], rxSync.data} == rxStCrc);

    // frame walker on the synchronised link clock rising edge
    always_ff @(posedge mclk or negedge rxSideAsyncReset_b) begin
        if (!rxSideAsyncReset_b) begin // RL21
            rxClkPrev_reg <= 1'b0;
            rxState_reg <= OFC_RX_HUNT;
            rxIdx_reg <= '0;
            calSh_reg <= 16'h0000;
            stSh_reg <= '0;
            chk_reg <= 4'h0;
        end else if (ce) begin
            rxClkPrev_reg <= rxSync.clk;
            if (rxRise && rxSync.sync) begin
                rxState_reg <= OFC_RX_CAL; // RL14
                rxIdx_reg <= LEFT_W'(1);
                calSh_reg <= {calSh_reg[14:0], rxSync.data};
            end else if (rxRise) begin
                rxIdx_reg <= rxIdx_reg + 1'b1;
                case (rxState_reg)
                    OFC_RX_HUNT: rxIdx_reg <= '0;
                    OFC_RX_CAL: begin
                        if (rxIdx_reg < LEFT_W'(OFC_CAL_BITS)) begin
                            calSh_reg <= {calSh_reg[14:0], rxSync.data};
                        end else begin
                            chk_reg <= {chk_reg[2:0], rxSync.data};
                        end
                        if (calDone) begin
                            rxState_reg <= OFC_RX_STAT;
                        end
                    end
                    OFC_RX_STAT: begin
                        if (rxIdx_reg < LEFT_W'(CAL_W + ST_W)) begin
                            stSh_reg <= {stSh_reg[ST_W-2:0], rxSync.data};
                        end else begin
                            chk_reg <= {chk_reg[2:0], rxSync.data};
                        end
                        if (stDone) begin
                            rxState_reg <= OFC_RX_HUNT;
                        end
                    end
                    default: rxState_reg <= OFC_RX_HUNT;
                endcase
            end
        end
    end

    // recovered values and one-cycle strobes on mclk
    always_ff @(posedge mclk or negedge rxSideAsyncReset_b) begin
        if (!rxSideAsyncReset_b) begin
            calendarOut <= 16'h0000;
            laneStatusOut <= '0;
            linkStatusOut <= 1'b0;
            calendarUpdate <= 1'b0;
            calendarError <= 1'b0;
            statusUpdate <= 1'b0;
            statusError <= 1'b0;
        end else if (ce) begin
            calendarUpdate <= calDone && calGood; // RL17
            calendarError <= calDone && !calGood; // RL20
            statusUpdate <= stDone && stGood; // RL18
            statusError <= stDone && !stGood; // RL19
            if (calDone) begin
                calendarOut <= calSh_reg;
            end
            if (stDone) begin
                laneStatusOut <= stSh_reg[ST_W-1:1];
                linkStatusOut <= stSh_reg[0];
            end
        end
    end

    // checksum error counters, a new error beats a clear
    always_ff @(posedge mclk or negedge rxSideAsyncReset_b) begin
        if (!rxSideAsyncReset_b) begin
            calErrCnt_reg <= '0;
            stErrCnt_reg <= '0;
        end else if (ce) begin
            if (errClr) begin
                calErrCnt_reg <= OFC_CNT_W'(calDone && !calGood);
                stErrCnt_reg <= OFC_CNT_W'(stDone && !stGood);
            end else begin
                calErrCnt_reg <= calErrCnt_reg + OFC_CNT_W'(calDone && !calGood);
                stErrCnt_reg <= stErrCnt_reg + OFC_CNT_W'(stDone && !stGood);
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    a_fcclk_half_rate: assert property ( // RL3
        @(posedge mclk) disable iff (!txSideAsyncReset_b)
        (ce && txSideAsyncReset_b) |=> (txLink.clk != $past(txLink.clk)))
        else $error("link clock did not toggle");

    a_data_on_fall: assert property ( // RL6
        @(posedge mclk) disable iff (!txSideAsyncReset_b)
        !$stable(txLink.data) |-> $fell(txLink.clk))
        else $error("tx data changed off the falling link clock");

    a_sync_one_bit: assert property ( // RL14
        @(posedge mclk) disable iff (!txSideAsyncReset_b)
        (txLoad ##1 ce [*3]) |-> !txLink.sync)
        else $error("sync held beyond one bit");

    a_frame_len_mode: assert property ( // RL8
        @(posedge mclk) disable iff (!txSideAsyncReset_b)
        txLoad |=> (txLeft_reg == (txEnaLat_reg ? LEFT_W'(FRAME_W - 1) : LEFT_W'(CAL_W - 1))))
        else $error("frame length does not match status enable");

    a_cal_only_frame: assert property ( // RL9
        @(posedge mclk) disable iff (!txSideAsyncReset_b)
        (txLoad && !ctrlEna_reg) |=> (txLeft_reg == LEFT_W'(CAL_W - 1)))
        else $error("status sent while disabled");

    a_cal_first_bit: assert property ( // RL12
        @(posedge mclk) disable iff (!txSideAsyncReset_b || !rst_b)
        txLoad |=> (txLink.data == $past(txCal_reg[15])) && txLink.sync)
        else $error("frame did not start with calendar msb");

    a_stat_strobe_pulse: assert property ( // RL18
        @(posedge mclk) disable iff (!rxSideAsyncReset_b)
        (statusUpdate && ce) |=> !statusUpdate && !statusError)
        else $error("status strobe longer than one cycle");

    a_stat_err_excl: assert property ( // RL19
        @(posedge mclk) disable iff (!rxSideAsyncReset_b)
        !(statusUpdate && statusError) && !(calendarUpdate && calendarError))
        else $error("update and error together");

    a_cal_err_cause: assert property ( // RL20
        @(posedge mclk) disable iff (!rxSideAsyncReset_b)
        calendarError |-> $past(calDone) && (calendarOut == $past(calSh_reg)))
        else $error("calendar error without a finished calendar");

    a_strobe_after_sync: assert property ( // RL23
        @(posedge mclk) disable iff (!rxSideAsyncReset_b)
        (calendarUpdate || statusUpdate) |-> $past(rxRise))
        else $error("strobe not tied to a synchronised edge");
endmodule

`default_nettype wire

/* File: verification/ofc_link_partner.sv */
// Purpose: far-side model, sends frames to the receiver and captures tx frames
// Assumes: 200 ns link clock, standing still between frames
// Notes: after a frame the data line shows the inverse of its last bit
`default_nettype none

module ofc_link_partner
    import ofc_pkg::*;
#(
    parameter int LANES = 4
) (
    input wire logic mclk,
    input wire ofc_link_t txLink,
    output var ofc_link_t fcOut
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle link before the first frame
    initial begin
        fcOut = 3'h0;
    end

    // checksum, msb first
    function automatic logic [3:0] crc_of(input logic [31:0] v, input int n);
        logic [3:0] c;
        logic fb;
        c = OFC_CRC_INIT;
        for (int i = n - 1; i >= 0; i--) begin
            fb = c[3] ^ v[i];
            c = {c[2:0], 1'b0} ^ (fb ? OFC_CRC_POLY : 4'h0);
        end
        return c;
    endfunction

    // whole frame, right justified
    function automatic logic [63:0] frame_of(input logic [15:0] cal,
        input logic [LANES-1:0] ln, input logic lk, input logic en);
        logic [63:0] f;
        f = {44'h0, cal, crc_of({16'h0, cal}, 16)};
        if (en) begin
            f = (f << (LANES + 5)) | 64'({ln, lk, crc_of(32'({ln, lk}), LANES + 1)});
        end
        return f;
    endfunction

    // one frame out, bit flip at index flip (-1 for none)
    task automatic send(input logic [63:0] f, input int n, input int flip);
        @(posedge mclk);
        for (int i = n - 1; i >= 0; i--) begin
            fcOut.data <= f[i] ^ (i == flip);
            fcOut.sync <= (i == n - 1);
            repeat (4) @(posedge mclk);
            fcOut.clk <= 1'b1;
            repeat (4) @(posedge mclk);
            fcOut.clk <= 1'b0;
        end
        fcOut.data <= ~fcOut.data;
        fcOut.sync <= 1'b0;
    endtask

    // sample tx frame on link clock rise; gap = mclk between last two rises
    task automatic capture(input int n, output logic [63:0] got, output int gap);
        int k;
        int cyc;
        int since;
        logic prev;
        k = -1;
        cyc = 0;
        since = 0;
        gap = 0;
        got = 64'h0;
        prev = txLink.clk;
        while (k < n - 1 && cyc < 600) begin
            @(negedge mclk);
            cyc++;
            since++;
            if (txLink.clk && !prev) begin
                k = txLink.sync ? 0 : (k < 0 ? -1 : k + 1);
                got = (k == 0) ? 64'(txLink.data) : (k > 0 ? {got[62:0], txLink.data} : got);
                gap = since;
                since = 0;
            end
            prev = txLink.clk;
        end
    endtask
endmodule

`default_nettype wire

/* File: verification/ofc_top_tb.sv */
// Purpose: self-checking bench of the flow-control block over AHB-Lite
// Assumes: one slave, zero-wait answers, partner at 200 ns link clock
// Notes: rx pulses counted continuously, checked as deltas per frame
`default_nettype none

`define CHK(g, e) \
    begin \
        nCompared++; \
        if ((g) !== (e)) begin \
            miscompares++; \
            $display("FAIL at %0t ns: got %0h expected %0h", $time, (g), (e)); \
        end \
    end

module ofc_top_tb
    import ofc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int LANES = 4;
    logic mclk, rst_b, txRst_b, rxRst_b, hsel, hwrite, hreadyout, hresp, linkStatusOut;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    ofc_link_t txLink, rxLinkPin;
    logic [15:0] calendarOut, cal;
    logic [LANES-1:0] laneStatusOut;
    logic statusUpdate, statusError, calendarUpdate, calendarError, en;
    logic [63:0] f, got;
    int miscompares, nCompared, cyc, gap, n;
    int pc[4];
    int old[4];
    localparam logic [3:0] RX_EXP [4] = '{4'ha, 4'h8, 4'h6, 4'h9};
    localparam logic [7:0] ADDRS [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18};

    ofc_top #(.LANES(LANES)) uut (.mclk(mclk), .rst_b(rst_b), .ce(1'b1),
        .txSideAsyncReset_b(txRst_b), .rxSideAsyncReset_b(rxRst_b), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .txLink(txLink), .rxLinkPin(rxLinkPin), .calendarOut(calendarOut),
        .laneStatusOut(laneStatusOut), .linkStatusOut(linkStatusOut),
        .statusUpdate(statusUpdate), .statusError(statusError),
        .calendarUpdate(calendarUpdate), .calendarError(calendarError));

    ofc_link_partner #(.LANES(LANES)) peer (.mclk(mclk), .txLink(txLink), .fcOut(rxLinkPin));

    // twice-rate clock, 25 ns
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // pulse counters and hang limit
    always @(posedge mclk) begin
        pc[0] += int'(calendarUpdate === 1'b1);
        pc[1] += int'(calendarError === 1'b1);
        pc[2] += int'(statusUpdate === 1'b1);
        pc[3] += int'(statusError === 1'b1);
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            closeOut();
        end
    end

    task automatic closeOut();
        $display("compared %0d, mismatched %0d", nCompared, miscompares);
        if (miscompares == 0 && nCompared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // wait for hready at a rising edge
    task automatic wait_ready();
        do begin
            @(posedge mclk);
        end while (hreadyout !== 1'b1);
    endtask

    // one single transfer: address phase, then data phase
    task automatic bus(input logic wr, input logic [7:0] a, input logic [2:0] sz,
        input logic [31:0] wd, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= OFC_HTRANS_NONSEQ;
        hwrite <= wr;
        hsize <= sz;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, OFC_HSIZE_WORD, d, r);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, OFC_HSIZE_WORD, 32'h0, r);
        `CHK(r, e);
        `CHK(hresp, 1'b0);
    endtask

    initial begin
        {rst_b, txRst_b, rxRst_b, hsel, hwrite} = 5'h0;
        {haddr, hwdata, htrans, hsize} = '0;
        repeat (10) @(posedge mclk);
        {rst_b, txRst_b, rxRst_b} <= 3'h7;
        @(posedge mclk);
        // reset values, unmapped included
        for (int i = 0; i < 6; i++) begin
            rdchk(ADDRS[i], 32'h0);
        end
        wr(OFC_TXCAL_ADDR, 32'hffffffff);
        rdchk(OFC_TXCAL_ADDR, 32'h0000ffff);
        bus(1'b1, OFC_TXCAL_ADDR, 3'h0, 32'h0, rd);
        rdchk(OFC_TXCAL_ADDR, 32'h0000ffff);
        wr(OFC_TXSTAT_ADDR, 32'hffffffff);
        rdchk(OFC_TXSTAT_ADDR, 32'h8000000f);
        wr(OFC_RXCAL_ADDR, 32'hffffffff);
        wr(8'h18, 32'hffffffff);
        rdchk(OFC_RXCAL_ADDR, 32'h0);
        rdchk(8'h18, 32'h0);
        $display("registers done");
        // tx frames with status off, then on
        wr(OFC_TXCAL_ADDR, 32'h0000a5c3);
        wr(OFC_TXSTAT_ADDR, 32'h80000009);
        for (int e = 0; e < 2; e++) begin
            wr(OFC_CTRL_ADDR, 32'(e));
            repeat (2) peer.capture(e ? 25 + LANES : 20, got, gap);
            `CHK(got, peer.frame_of(16'ha5c3, 4'h9, 1'b1, e[0]));
            `CHK(gap, OFC_FC_DIV);
        end
        $display("tx done");
        // rx frames: good, calendar only, bad calendar, bad status
        for (int c = 0; c < 4; c++) begin
            cal = 16'h1234 + 16'(c) * 16'h1111;
            en = (c != 1);
            n = en ? 25 + LANES : 20;
            f = peer.frame_of(cal, 4'(c + 5), c[0], en);
            old = pc;
            peer.send(f, n, c == 2 ? n - 17 : (c == 3 ? 0 : -1));
            repeat (12) @(posedge mclk);
            `CHK({pc[0] - old[0] == 1, pc[1] - old[1] == 1, pc[2] - old[2] == 1, pc[3] - old[3] == 1}, RX_EXP[c]);
            `CHK(calendarOut, cal);
            if (c == 0) begin
                `CHK({linkStatusOut, laneStatusOut}, 5'h05);
            end
        end
        rdchk(OFC_RXCAL_ADDR, 32'h00004567);
        rdchk(OFC_RXSTAT_ADDR, 32'h80000008);
        rdchk(OFC_RXERR_ADDR, 32'h00010001);
        wr(OFC_RXERR_ADDR, 32'h0);
        rdchk(OFC_RXERR_ADDR, 32'h0);
        $display("rx done");
        // separate resets of the two halves
        txRst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(txLink, 3'h0);
        `CHK(calendarOut, 16'h4567);
        txRst_b <= 1'b1;
        rxRst_b <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK(calendarOut, 16'h0);
        rxRst_b <= 1'b1;
        peer.capture(25 + LANES, got, gap);
        `CHK(got, peer.frame_of(16'ha5c3, 4'h9, 1'b1, 1'b1));
        $display("resets done");
        closeOut();
    end
endmodule

`default_nettype wire
